// *** logic/sbcr_pkg.sv ***
// Shared constants for the serial banked control register and its controller.
// Assumes both ends are clocked by the same system clock at 250 MHz.
package sbcr_pkg;
    localparam int WORD_BITS  = 13;
    localparam int DATA_BITS  = 11;
    localparam int ADDR_BITS  = 2;
    localparam int BANK_COUNT = 4;
    localparam int DATA_LSB   = 2;
    localparam int ADDR_LO    = 0;
    localparam int ADDR_HI    = 1;
    typedef logic [DATA_BITS-1:0] sbcr_bank_t;
    typedef logic [ADDR_BITS-1:0] sbcr_addr_t;
    typedef logic [WORD_BITS-1:0] sbcr_word_t;
    // Power-on values per bank, bit 0 of each constant is word position 2
    localparam sbcr_bank_t POR_BANK0 = 11'h1ef;
    localparam sbcr_bank_t POR_BANK1 = 11'h041;
    localparam sbcr_bank_t POR_BANK2 = 11'h02f;
    localparam sbcr_bank_t POR_BANK3 = 11'h01c;
    // Link clock half period in system clocks (divider in the controller)
    localparam int LINK_HALF_DEFAULT = 4;
    // Controller register map
    localparam logic [1:0] CMD_ADDR    = 2'h0;
    localparam logic [1:0] STATUS_ADDR = 2'h1;
    localparam int CMD_GO_BIT = 15;
endpackage

// *** logic/sbcr_link_if.sv ***
// Four-wire serial link between the controller and the banked register.
// Both ends run on the same system clock; the link clock is a plain wire.
interface sbcr_link_if;
    logic serialConfigClock;
    logic serialConfigDataIn;
    logic bankLatchShiftSelect;
    logic serialConfigDataOut;
    modport device (input serialConfigClock, input serialConfigDataIn,
                    input bankLatchShiftSelect, output serialConfigDataOut);
    modport controller (output serialConfigClock, output serialConfigDataIn,
                        output bankLatchShiftSelect, input serialConfigDataOut);
endinterface

// *** logic/sbcr_edge_sync.sv ***
// Two-flop synchroniser with rising-edge detect on the synchronised level.
// Assumes the input is asynchronous to clock.
module sbcr_edge_sync (
    input  wire logic clock,
    input  wire logic asyncIn,
    output logic      level,
    output logic      rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sbcr_sync_t;
    sbcr_sync_t s_q;
    sbcr_sync_t s_d;
    always_comb begin
        s_d      = s_q;
        s_d.meta = asyncIn;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end
    // No reset: a stale level settles within two cycles
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end
    assign level = s_q.sync;
    assign rise  = s_q.sync & ~s_q.prev;
endmodule // sbcr_edge_sync

// *** logic/sbcr_device.sv ***
// Device end: thirteen-bit serial shift register and four latch banks.
// Assumes link pins are asynchronous; reset models power-up or sleep exit.
// Functional notes
// - Thirteen-bit shift register: eleven data, two address
// - Four banks of eleven latch bits
// - Shift on serial clock rise while select low
// - Select rise copies data to addressed bank
// - Controller keeps select high when idle
// - Select high stops the shift register
// - Controller loads only when awake and not idle
// - Positions two to twelve carry data bits
// - Last two bits shifted are bank address
// - Reset forces banks to power-on values
// - Serial output taken from shift register
// - Shift register has no reset
// - Early select rise loads garbage bank
// - Controller shifts full word before first latch
// - Position zero is address low bit
module sbcr_device
    import sbcr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset,
    sbcr_link_if.device     link,
    output sbcr_pkg::sbcr_bank_t bank0,
    output sbcr_pkg::sbcr_bank_t bank1,
    output sbcr_pkg::sbcr_bank_t bank2,
    output sbcr_pkg::sbcr_bank_t bank3
);
    import sbcr_pkg::*;

    typedef struct packed {
        sbcr_word_t shift;
        sbcr_bank_t [BANK_COUNT-1:0] banks;
    } sbcr_dev_t;

    sbcr_dev_t s_q;
    sbcr_dev_t s_d;
    logic clkRise;
    logic selLevel;
    logic selRise;
    logic dataLevel;

    sbcr_edge_sync clkSync (.clock(clock), .asyncIn(link.serialConfigClock),
                            .level(), .rise(clkRise));
    sbcr_edge_sync selSync (.clock(clock), .asyncIn(link.bankLatchShiftSelect),
                            .level(selLevel), .rise(selRise));
    sbcr_edge_sync datSync (.clock(clock), .asyncIn(link.serialConfigDataIn),
                            .level(dataLevel), .rise());

    always_comb begin
        s_d        = s_q;
        // Data is aligned with clock through equal synchroniser depth
        if (!selLevel && clkRise) begin
            // Last bit in lands at position zero, bits move upward
            s_d.shift = {s_q.shift[WORD_BITS-2:0], dataLevel};
        end
        if (selRise) begin
            s_d.banks[{s_q.shift[ADDR_HI], s_q.shift[ADDR_LO]}] =
                s_q.shift[WORD_BITS-1:DATA_LSB];
        end
        if (reset) begin
            s_d.banks[0] = POR_BANK0;
            s_d.banks[1] = POR_BANK1;
            s_d.banks[2] = POR_BANK2;
            s_d.banks[3] = POR_BANK3;
        end
    end

    // Shift field deliberately not reset
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign link.serialConfigDataOut = s_q.shift[0];
    assign bank0 = s_q.banks[0];
    assign bank1 = s_q.banks[1];
    assign bank2 = s_q.banks[2];
    assign bank3 = s_q.banks[3];
endmodule // sbcr_device

// *** logic/sbcr_controller.sv ***
// Controller end: shifts one 13-bit word out and pulses the latch select.
// Assumes software issues commands through the plain register port.
module sbcr_controller
    import sbcr_pkg::*;
#(
    parameter int LINK_HALF = LINK_HALF_DEFAULT
)(
    input  wire logic        clock,
    input  wire logic        reset,
    sbcr_link_if.controller  link,
    input  wire logic [1:0]  regAddr,
    input  wire logic [15:0] regWriteData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regReadData,
    input  wire logic        powerDownN,
    input  wire logic        idleServo
);
    import sbcr_pkg::*;

    typedef enum logic [1:0] {
        IDLE  = 2'b00,
        SHIFT = 2'b01,
        LATCH = 2'b10
    } sbcr_state_t;

    typedef struct packed {
        sbcr_state_t state;
        sbcr_word_t  word;
        logic [3:0]  bitCount;
        logic [7:0]  div;
        logic        sclk;
        logic        sel;
        logic        sdo;
        logic        done;
        logic        refused;
        logic [15:0] rdata;
    } sbcr_ctl_t;

    sbcr_ctl_t s_q;
    sbcr_ctl_t s_d;
    logic      powerDownNLevel;
    logic      idleServoLevel;

    // Power pins are asynchronous to clock
    sbcr_edge_sync pwrSync (.clock(clock), .asyncIn(powerDownN),
                            .level(powerDownNLevel), .rise());
    sbcr_edge_sync idleSync (.clock(clock), .asyncIn(idleServo),
                             .level(idleServoLevel), .rise());

    always_comb begin
        s_d = s_q;
        s_d.rdata = 16'h0000;
        if (regRead) begin
            s_d.rdata = (regAddr == STATUS_ADDR) ?
                {13'h0000, s_q.refused, s_q.done, s_q.state != IDLE} : 16'h0000;
        end
        case (s_q.state)
            IDLE: begin
                s_d.sel = 1'b1;
                if (regWrite && regAddr == CMD_ADDR && regWriteData[CMD_GO_BIT]) begin
                    if (powerDownNLevel && !idleServoLevel) begin
                        s_d.word     = regWriteData[WORD_BITS-1:0];
                        s_d.state    = SHIFT;
                        s_d.sel      = 1'b0;
                        s_d.bitCount = 4'(WORD_BITS - 1);
                        s_d.sdo      = regWriteData[WORD_BITS-1];
                        s_d.div      = 8'(LINK_HALF - 1);
                        s_d.done     = 1'b0;
                        s_d.refused  = 1'b0;
                    end else begin
                        s_d.refused = 1'b1;
                    end
                end
            end
            SHIFT: begin
                if (s_q.div != 8'h00) begin
                    s_d.div = s_q.div - 8'h01;
                end else begin
                    s_d.div  = 8'(LINK_HALF - 1);
                    s_d.sclk = ~s_q.sclk;
                    if (s_q.sclk) begin
                        // Falling edge: advance to next bit, position 0 last
                        if (s_q.bitCount == 4'h0) begin
                            s_d.state = LATCH;
                        end else begin
                            s_d.bitCount = s_q.bitCount - 4'h1;
                            s_d.sdo      = s_q.word[s_q.bitCount - 4'h1];
                        end
                    end
                end
            end
            LATCH: begin
                s_d.sel   = 1'b1;
                s_d.done  = 1'b1;
                s_d.state = IDLE;
            end
            default: s_d.state = IDLE;
        endcase
        if (reset) begin
            s_d = '0;
            s_d.sel = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign link.serialConfigClock    = s_q.sclk;
    assign link.serialConfigDataIn   = s_q.sdo;
    assign link.bankLatchShiftSelect = s_q.sel;
    assign regReadData = s_q.rdata;
endmodule // sbcr_controller

// *** test/sbcr_props.sv ***
// Link and latch-bank checker for the serial banked register.
// Assumes one system clock and a link half period of 4 clocks.
module sbcr_props
    import sbcr_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 reset,
    input wire logic                 serialConfigClock,
    input wire logic                 serialConfigDataIn,
    input wire logic                 bankLatchShiftSelect,
    input wire logic                 serialConfigDataOut,
    input wire sbcr_pkg::sbcr_bank_t bank0,
    input wire sbcr_pkg::sbcr_bank_t bank1,
    input wire sbcr_pkg::sbcr_bank_t bank2,
    input wire sbcr_pkg::sbcr_bank_t bank3
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbcr_pkg::*;
    logic [12:0] shiftCopy_q;
    logic [4:0]  riseCount_q;
    logic [43:0] allBanks;
    logic        shifted_q;
    assign allBanks = {bank3, bank2, bank1, bank0};
    // Serial out is undefined until a full word has gone through
    always_ff @(posedge clock) begin
        if (reset) begin
            shifted_q <= 1'b0;
        end else if (riseCount_q == 5'hd) begin
            shifted_q <= 1'b1;
        end
    end
    // Shadow of the word as seen on the wire
    always_ff @(posedge clock) begin
        if (reset || bankLatchShiftSelect) begin
            riseCount_q <= 5'h0;
        end else if ($rose(serialConfigClock)) begin
            riseCount_q <= riseCount_q + 5'h1;
            shiftCopy_q <= {shiftCopy_q[11:0], serialConfigDataIn};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_idle_clock; bankLatchShiftSelect |-> !serialConfigClock; endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("link clock high while idle");
    property p_word_len; $rose(bankLatchShiftSelect) |-> riseCount_q == 5'hd; endproperty
    a_word_len: assert property (p_word_len) else $error("word not thirteen bits");
    property p_data_hold; serialConfigClock |-> $stable(serialConfigDataIn); endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    property p_half; $rose(serialConfigClock) |-> serialConfigClock[*4] ##1 !serialConfigClock;
    endproperty
    a_half: assert property (p_half) else $error("link clock high time wrong");
    property p_latch;
        $rose(bankLatchShiftSelect) |-> ##[1:6] allBanks[shiftCopy_q[1:0]*11 +: 11] == shiftCopy_q[12:2];
    endproperty
    a_latch: assert property (p_latch) else $error("addressed bank not loaded");
    property p_hold; !bankLatchShiftSelect && !$past(bankLatchShiftSelect, 6) |-> $stable(allBanks);
    endproperty
    a_hold: assert property (p_hold) else $error("bank changed while shifting");
    property p_por; $fell(reset) |-> bank0 == POR_BANK0 && bank1 == POR_BANK1
        && bank2 == POR_BANK2 && bank3 == POR_BANK3; endproperty
    a_por: assert property (p_por) else $error("banks not at power-on values");
    property p_sdo; shifted_q && bankLatchShiftSelect && $past(bankLatchShiftSelect, 4)
        |-> $stable(serialConfigDataOut);
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial out moved while idle");
    property p_back; $fell(bankLatchShiftSelect) |-> ##[1:120] bankLatchShiftSelect; endproperty
    a_back: assert property (p_back) else $error("select left low");
endmodule // sbcr_props

// *** test/serial_banked_control_register_test.sv ***
// Bench joining controller and device ends, with a bank model.
// Assumes the controller at its default link divider.
module serial_banked_control_register_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sbcr_pkg::*;
    logic        clock, reset, regWrite, regRead, powerDownN, idleServo;
    logic [1:0]  regAddr;
    logic [15:0] regWriteData, regReadData, st;
    sbcr_bank_t  bank0, bank1, bank2, bank3, expBank [4];
    int          n_fail, checked;
    sbcr_link_if link ();
    sbcr_device sbcr_device_i (.clock(clock), .reset(reset), .link(link), .bank0(bank0),
        .bank1(bank1), .bank2(bank2), .bank3(bank3));
    sbcr_controller sbcr_controller_i (.clock(clock), .reset(reset), .link(link),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .powerDownN(powerDownN), .idleServo(idleServo));
    sbcr_props sbcr_props_i (.clock(clock), .reset(reset),
        .serialConfigClock(link.serialConfigClock), .serialConfigDataIn(link.serialConfigDataIn),
        .bankLatchShiftSelect(link.bankLatchShiftSelect),
        .serialConfigDataOut(link.serialConfigDataOut),
        .bank0(bank0), .bank1(bank1), .bank2(bank2), .bank3(bank3));
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] want, string what);
        checked++;
        if (got !== want) begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [15:0] d);
        regAddr <= a; regWriteData <= d; regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read data stands one cycle only, so sample just after its edge
    task automatic rd(logic [1:0] a, output logic [15:0] d);
        regAddr <= a; regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regReadData;
        @(posedge clock);
    endtask
    task automatic cmpBanks();
        logic [43:0] b;
        b = {bank3, bank2, bank1, bank0};
        for (int i = 0; i < 4; i++) chk(16'(b[i*11 +: 11]), 16'(expBank[i]), "bank");
    endtask
    task automatic load(logic [12:0] w);
        wr(CMD_ADDR, 16'h8000 | 16'(w));
        expBank[w[1:0]] = w[12:2];
        for (int i = 0; i < 300; i++) begin
            rd(STATUS_ADDR, st);
            if (st[0] === 1'b0) break;
            if (i == 299) begin n_fail++; tally_and_finish(); end
        end
        chk(st & 16'h0003, 16'h0002, "done");
        repeat (8) @(posedge clock);
        cmpBanks();
        chk(16'(link.serialConfigDataOut), 16'(w[0]), "sdo");
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        reset = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 2'h0;
        regWriteData = 16'h0; powerDownN = 1'b1; idleServo = 1'b0;
        expBank = '{POR_BANK0, POR_BANK1, POR_BANK2, POR_BANK3};
        void'($urandom(29203));
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        cmpBanks();
        $display("test power-on done");
        for (int i = 0; i < 12; i++) load(i < 4 ? {11'($urandom), 2'(i)} : 13'($urandom));
        $display("test bank loads done");
        for (int i = 0; i < 2; i++) begin
            powerDownN <= 1'(i); idleServo <= 1'(i);
            // Let the pin synchronisers settle first
            repeat (3) @(posedge clock);
            wr(CMD_ADDR, 16'h8000 | 16'($urandom));
            rd(STATUS_ADDR, st);
            chk(st & 16'h0005, 16'h0004, "refused");
            cmpBanks();
        end
        powerDownN <= 1'b1; idleServo <= 1'b0;
        $display("test refusal done");
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        expBank = '{POR_BANK0, POR_BANK1, POR_BANK2, POR_BANK3};
        @(posedge clock);
        cmpBanks();
        load(13'($urandom));
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // serial_banked_control_register_test
